// *** rtl/sqa_ctrl.sv ***
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - byte sync enabled per channel only while its enable bit is one
// - lock select zero locks pll to reference, one locks to data
// - lock indicator forced to zero while lock select is zero
// - loopback bit routes channel transmitter into its own receiver
// - register loopback turns off the channel's serial output
// - word align disable bit stops receiver word alignment
// - realign rising edge realigns once on next comma
// - channel joins multichannel alignment only while participate bit set
// - two-bit sync mode: 00 none, 10 twin, 01 quad, 11 undefined
// - single-lane resync rising edge resets channel buffer pointers
// - bit 4 rise resyncs pair a-b, bit 5 rise resyncs pair c-d
// - bit 6 rise resyncs all four channels together
// - xaui select forces xaui link machine, per-channel selects ignored
// - every control bit clears to zero on reset
module sqa_ctrl (
	input  wire logic                        ref_clk,
	input  wire logic                        srst,
	input  wire logic [sqa_pkg::ADDR_W-1:0]  addr,
	input  wire logic [sqa_pkg::DATA_W-1:0]  wdata,
	input  wire logic                        wr_stb,
	input  wire logic                        rd_stb,
	output logic      [sqa_pkg::DATA_W-1:0]  rdata,
	input  wire logic [3:0]                  pll_locked,
	output logic      [3:0]                  byte_sync_enable,
	output logic      [3:0]                  rx_pll_lock_select,
	output logic      [3:0]                  lock_indicator,
	output logic      [3:0]                  serial_loopback_enable,
	output logic      [3:0]                  tx_serial_out_enable,
	output logic      [3:0]                  word_align_disable,
	output logic      [3:0]                  word_realign_pulse,
	output logic      [3:0]                  multichan_align_participate,
	output logic      [7:0]                  multichan_sync_select,
	output logic      [3:0]                  grp_none,
	output logic      [3:0]                  grp_twin,
	output logic      [3:0]                  grp_quad,
	output logic      [3:0]                  ptr_reset_pulse,
	output logic      [3:0]                  xaui_sm_use
);
	logic [7:0] r0_r;
	logic [7:0] r1_r;
	logic [7:0] r2_r;
	logic [7:0] r3_r;
	logic [7:0] r4_r;
	logic [3:0] lsm_r;
	logic [7:0] rdata_nxt;
	logic [3:0] sync_en_r;
	logic [3:0] lock_sel_r;
	logic [3:0] lki_r;
	logic [3:0] loop_r;
	logic [3:0] txoe_r;
	logic [3:0] nowd_r;
	logic [3:0] realign_r;
	logic [3:0] part_r;
	logic [7:0] smode_r;
	logic [3:0] gnone_r;
	logic [3:0] gtwin_r;
	logic [3:0] gquad_r;
	logic [3:0] ptr_r;
	logic [3:0] xaui_r;

	// address decode
	wire hit0 = addr == sqa_pkg::OFF_RX_SYNC_LOCK;
	wire hit1 = addr == sqa_pkg::OFF_LOOP_ALIGN;
	wire hit2 = addr == sqa_pkg::OFF_REALIGN_MC;
	wire hit3 = addr == sqa_pkg::OFF_SYNC_MODE;
	wire hit4 = addr == sqa_pkg::OFF_RESYNC_LINK;
	wire hit5 = addr == sqa_pkg::OFF_LINK_SM_SEL;

	// edge detection on realign and resync bits
	sqa_edge_if rl_if ();
	sqa_edge_if rs_if ();
	assign rl_if.level = r2_r;
	assign rs_if.level = r4_r;
	sqa_edge_det u_rl_edge (
		.ref_clk (ref_clk),
		.srst    (srst),
		.e       (rl_if.det)
	);
	sqa_edge_det u_rs_edge (
		.ref_clk (ref_clk),
		.srst    (srst),
		.e       (rs_if.det)
	);

	wire [3:0] realign_rise = rl_if.rise[3:0];
	wire       pair_ab      = rs_if.rise[sqa_pkg::BIT_PAIR_AB];
	wire       pair_cd      = rs_if.rise[sqa_pkg::BIT_PAIR_CD];
	wire       group_rs     = rs_if.rise[sqa_pkg::BIT_GROUP];
	wire [3:0] resync_all   = rs_if.rise[3:0]
		| {pair_cd, pair_cd, pair_ab, pair_ab}
		| {4{group_rs}};
	wire       xaui_q       = r4_r[sqa_pkg::BIT_XAUI];
	wire [3:0] xaui_nxt     = xaui_q ? 4'hF : lsm_r;

	// register fields, channel a in the lowest bit of each nibble
	wire [3:0] fld_sync_en  = r0_r[sqa_pkg::LO_NIB +: 4];
	wire [3:0] fld_lock_sel = r0_r[sqa_pkg::HI_NIB +: 4];
	wire [3:0] fld_loop     = r1_r[sqa_pkg::LO_NIB +: 4];
	wire [3:0] fld_nowd     = r1_r[sqa_pkg::HI_NIB +: 4];
	wire [3:0] fld_part     = r2_r[sqa_pkg::HI_NIB +: 4];
	// serial output is off whenever register loopback is on
	wire [3:0] txoe_nxt     = ~fld_loop;

	// read mux; unmapped addresses read zero
	assign rdata_nxt = hit0 ? r0_r :
		hit1 ? r1_r :
		hit2 ? r2_r :
		hit3 ? r3_r :
		hit4 ? r4_r :
		hit5 ? {4'h0, lsm_r} : 8'h00;

	// per-channel decode, channel i at bit i / pair 2i
	logic [3:0] gn_nxt;
	logic [3:0] gt_nxt;
	logic [3:0] gq_nxt;
	logic [3:0] lki_nxt;
	genvar i;
	generate
		for (i = 0; i < sqa_pkg::NCH; i++) begin : g_ch
			wire [1:0] m = r3_r[2*i +: 2];
			sqa_pkg::sqa_group_e grp;
			// code 11 is undefined and selects no grouping at all
			always_comb begin
				unique case (m)
					sqa_pkg::SYNC_NONE:  grp = sqa_pkg::SQA_GRP_NONE;
					sqa_pkg::SYNC_TWIN:  grp = sqa_pkg::SQA_GRP_TWIN;
					sqa_pkg::SYNC_QUAD:  grp = sqa_pkg::SQA_GRP_QUAD;
					sqa_pkg::SYNC_UNDEF: grp = sqa_pkg::SQA_GRP_BAD;
				endcase
			end
			assign gn_nxt[i] = grp == sqa_pkg::SQA_GRP_NONE;
			assign gt_nxt[i] = grp == sqa_pkg::SQA_GRP_TWIN;
			assign gq_nxt[i] = grp == sqa_pkg::SQA_GRP_QUAD;
			// lock indicator only meaningful when locked to data
			assign lki_nxt[i] = r0_r[sqa_pkg::HI_NIB + i] & pll_locked[i];
		end
	endgenerate

	// write enables, one per register; unmapped addresses hit none
	wire we0 = wr_stb && hit0;
	wire we1 = wr_stb && hit1;
	wire we2 = wr_stb && hit2;
	wire we3 = wr_stb && hit3;
	wire we4 = wr_stb && hit4;
	wire we5 = wr_stb && hit5;

	// five control registers, all cleared by reset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r0_r <= sqa_pkg::RST_REG;
		end else if (we0) begin
			r0_r <= wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r1_r <= sqa_pkg::RST_REG;
		end else if (we1) begin
			r1_r <= wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r2_r <= sqa_pkg::RST_REG;
		end else if (we2) begin
			r2_r <= wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r3_r <= sqa_pkg::RST_REG;
		end else if (we3) begin
			r3_r <= wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r4_r <= sqa_pkg::RST_REG;
		end else if (we4) begin
			r4_r <= wdata;
		end
	end

	// per-channel link machine selects, one nibble at the spare offset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lsm_r <= 4'h0;
		end else if (we5) begin
			lsm_r <= wdata[3:0];
		end
	end

	// read data stand for the one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata <= sqa_pkg::RST_REG;
		end else begin
			rdata <= rd_stb ? rdata_nxt : 8'h00;
		end
	end

	// output flops, one per field
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync_en_r <= 4'h0;
		end else begin
			sync_en_r <= fld_sync_en;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lock_sel_r <= 4'h0;
		end else begin
			lock_sel_r <= fld_lock_sel;
		end
	end

	// lock indicator reads zero while locked to the reference clock
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lki_r <= 4'h0;
		end else begin
			lki_r <= lki_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			loop_r <= 4'h0;
		end else begin
			loop_r <= fld_loop;
		end
	end

	// serial output held off during reset, safe before state is known
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			txoe_r <= 4'h0;
		end else begin
			txoe_r <= txoe_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			nowd_r <= 4'h0;
		end else begin
			nowd_r <= fld_nowd;
		end
	end

	// one pulse per rising edge of a realign bit
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			realign_r <= 4'h0;
		end else begin
			realign_r <= realign_rise;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			part_r <= 4'h0;
		end else begin
			part_r <= fld_part;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			smode_r <= 8'h00;
		end else begin
			smode_r <= r3_r;
		end
	end

	// mode fields clear to 00, so reset already reads as no grouping
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			gnone_r <= 4'hF;
		end else begin
			gnone_r <= gn_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			gtwin_r <= 4'h0;
		end else begin
			gtwin_r <= gt_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			gquad_r <= 4'h0;
		end else begin
			gquad_r <= gq_nxt;
		end
	end

	// pulse resets the channel's buffer write and read pointers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ptr_r <= 4'h0;
		end else begin
			ptr_r <= resync_all;
		end
	end

	// quad xaui select overrides every per-channel link machine select
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			xaui_r <= 4'h0;
		end else begin
			xaui_r <= xaui_nxt;
		end
	end

	assign byte_sync_enable            = sync_en_r;
	assign rx_pll_lock_select          = lock_sel_r;
	assign lock_indicator              = lki_r;
	assign serial_loopback_enable      = loop_r;
	assign tx_serial_out_enable        = txoe_r;
	assign word_align_disable          = nowd_r;
	assign word_realign_pulse          = realign_r;
	assign multichan_align_participate = part_r;
	assign multichan_sync_select       = smode_r;
	assign grp_none                    = gnone_r;
	assign grp_twin                    = gtwin_r;
	assign grp_quad                    = gquad_r;
	assign ptr_reset_pulse             = ptr_r;
	assign xaui_sm_use                 = xaui_r;
endmodule : sqa_ctrl
`default_nettype wire

// *** inc/sqa_pkg.sv ***
`default_nettype none
package sqa_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;
	localparam int NCH = 4;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_RX_SYNC_LOCK  = 20'h3_0800;
	localparam logic [ADDR_W-1:0] OFF_LOOP_ALIGN    = 20'h3_0801;
	localparam logic [ADDR_W-1:0] OFF_REALIGN_MC    = 20'h3_0810;
	localparam logic [ADDR_W-1:0] OFF_SYNC_MODE     = 20'h3_0811;
	localparam logic [ADDR_W-1:0] OFF_RESYNC_LINK   = 20'h3_0820;
	localparam logic [ADDR_W-1:0] OFF_LINK_SM_SEL   = 20'h3_0821;

	// reset values
	localparam logic [DATA_W-1:0] RST_REG = 8'h00;

	// field positions
	localparam int LO_NIB = 0;
	localparam int HI_NIB = 4;
	localparam int BIT_PAIR_AB = 4;
	localparam int BIT_PAIR_CD = 5;
	localparam int BIT_GROUP = 6;
	localparam int BIT_XAUI = 7;

	// sync mode encodings
	localparam logic [1:0] SYNC_NONE = 2'h0;
	localparam logic [1:0] SYNC_QUAD = 2'h1;
	localparam logic [1:0] SYNC_TWIN = 2'h2;
	localparam logic [1:0] SYNC_UNDEF = 2'h3;

	typedef enum logic [3:0] {
		SQA_GRP_NONE = 4'b0001,
		SQA_GRP_TWIN = 4'b0010,
		SQA_GRP_QUAD = 4'b0100,
		SQA_GRP_BAD  = 4'b1000
	} sqa_group_e;
endpackage : sqa_pkg
`default_nettype wire

// *** inc/sqa_edge_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sqa_edge_if;
	logic [sqa_pkg::DATA_W-1:0] level;
	logic [sqa_pkg::DATA_W-1:0] rise;
	modport src (output level, input rise);
	modport det (input level, output rise);
endinterface : sqa_edge_if
`default_nettype wire

// *** rtl/sqa_edge_det.sv ***
`timescale 1ns/1ps
`default_nettype none
module sqa_edge_det (
	input  wire logic ref_clk,
	input  wire logic srst,
	sqa_edge_if.det   e
);
	logic [sqa_pkg::DATA_W-1:0] prev_r;

	// prev clears with the control registers, so no edge follows reset
	assign e.rise = e.level & ~prev_r;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			prev_r <= sqa_pkg::RST_REG;
		end else begin
			prev_r <= e.level;
		end
	end
endmodule : sqa_edge_det
`default_nettype wire

// *** test/sqa_ctrl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sqa_ctrl_monitor (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic [19:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr_stb,
	input wire logic [7:0]  rdata,
	input wire logic [3:0]  pll_locked,
	input wire logic [3:0]  byte_sync_enable,
	input wire logic [3:0]  rx_pll_lock_select,
	input wire logic [3:0]  lock_indicator,
	input wire logic [3:0]  serial_loopback_enable,
	input wire logic [3:0]  tx_serial_out_enable,
	input wire logic [3:0]  word_align_disable,
	input wire logic [3:0]  word_realign_pulse,
	input wire logic [3:0]  multichan_align_participate,
	input wire logic [7:0]  multichan_sync_select,
	input wire logic [3:0]  grp_none,
	input wire logic [3:0]  grp_twin,
	input wire logic [3:0]  grp_quad,
	input wire logic [3:0]  ptr_reset_pulse,
	input wire logic [3:0]  xaui_sm_use
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic [3:0] md_n, md_t, md_q;
	for (genvar i = 0; i < 4; i++) begin : g_md
		assign md_n[i] = multichan_sync_select[2*i+:2] == sqa_pkg::SYNC_NONE;
		assign md_t[i] = multichan_sync_select[2*i+:2] == sqa_pkg::SYNC_TWIN;
		assign md_q[i] = multichan_sync_select[2*i+:2] == sqa_pkg::SYNC_QUAD;
	end
	sequence s_wr(logic [19:0] o);
		wr_stb && addr == o;
	endsequence
	a_sync_lock : assert property (
		s_wr(sqa_pkg::OFF_RX_SYNC_LOCK) |->
		##2 {rx_pll_lock_select, byte_sync_enable} == $past(wdata, 2)
	) else $error("sync or lock select not following write");
	a_lock_gate : assert property (
		lock_indicator == (rx_pll_lock_select & $past(pll_locked))
	) else $error("lock indicator not gated by lock select");
	a_loop_route : assert property (
		s_wr(sqa_pkg::OFF_LOOP_ALIGN) |->
		##2 {word_align_disable, serial_loopback_enable} == $past(wdata, 2)
	) else $error("loopback or align disable not following write");
	a_tx_off : assert property (
		(serial_loopback_enable & tx_serial_out_enable) == 4'h0
	) else $error("serial output on during loopback");
	a_mc_join : assert property (
		s_wr(sqa_pkg::OFF_REALIGN_MC) |->
		##2 multichan_align_participate == $past(wdata[7:4], 2)
	) else $error("participate bits not following write");
	a_mode_decode : assert property (
		grp_none == md_n && grp_twin == md_t && grp_quad == md_q
	) else $error("group decode wrong");
	a_realign_src : assert property (
		word_realign_pulse != 4'h0 |->
		$past(wr_stb, 2) && $past(addr, 2) == sqa_pkg::OFF_REALIGN_MC
	) else $error("realign pulse without write");
	a_resync_src : assert property (
		ptr_reset_pulse != 4'h0 |->
		$past(wr_stb, 2) && $past(addr, 2) == sqa_pkg::OFF_RESYNC_LINK
	) else $error("pointer reset without write");
	a_xaui_force : assert property (
		s_wr(sqa_pkg::OFF_RESYNC_LINK) ##0 wdata[7] |-> ##2 xaui_sm_use == 4'hF
	) else $error("xaui select not forcing all channels");
	a_reset_clear : assert property (
		$fell(srst) |-> rdata == 8'h00 && {byte_sync_enable, rx_pll_lock_select,
		serial_loopback_enable, ptr_reset_pulse, xaui_sm_use} == 20'h0_0000
	) else $error("outputs not cleared by reset");
endmodule : sqa_ctrl_monitor
bind sqa_ctrl sqa_ctrl_monitor u_mon (.*);
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [19:0] addr = 20'h0_0000;
	logic [7:0] wdata = 8'h00, rdata, multichan_sync_select;
	logic [3:0] pll_locked = 4'hF, byte_sync_enable, rx_pll_lock_select;
	logic [3:0] lock_indicator, serial_loopback_enable, tx_serial_out_enable;
	logic [3:0] word_align_disable, word_realign_pulse, ptr_reset_pulse;
	logic [3:0] multichan_align_participate, grp_none, grp_twin, grp_quad;
	logic [3:0] xaui_sm_use;
	int error_cnt = 0, compares = 0;
	logic [7:0] rs_d[5] = '{8'h01, 8'h11, 8'h31, 8'h71, 8'hF1};
	logic [3:0] rs_p[5] = '{4'h1, 4'h3, 4'hC, 4'hF, 4'h0};
	sqa_ctrl uut (.*);
	always #10 ref_clk = ~ref_clk;
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic st();
		@(posedge ref_clk);
		#1;
	endtask : st
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [19:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		chk("rdata", e, rdata);
	endtask : rd
	task automatic reset_chk();
		chk("outs", 32'h0000_0000, {byte_sync_enable, rx_pll_lock_select,
			lock_indicator, serial_loopback_enable, word_realign_pulse,
			ptr_reset_pulse, multichan_sync_select});
		chk("outs2", 12'h000, {word_align_disable,
			multichan_align_participate, xaui_sm_use});
		chk("groups", 12'hF00, {grp_none, grp_twin, grp_quad});
		chk("tx_en", 4'hF, tx_serial_out_enable);
	endtask : reset_chk
	task automatic final_report();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		st();
		st();
		reset_chk();
		for (int i = 0; i < 2; i++) rd(sqa_pkg::OFF_RX_SYNC_LOCK + 20'(i), 8'h00);
		rd(sqa_pkg::OFF_RESYNC_LINK, 8'h00);
		wr(20'h3_0830, 8'hFF);
		rd(20'h3_0830, 8'h00);
		wr(sqa_pkg::OFF_RX_SYNC_LOCK, 8'hA5);
		st();
		st();
		chk("byte_sync", 4'h5, byte_sync_enable);
		chk("lock_sel", 4'hA, rx_pll_lock_select);
		chk("lock_ind", 4'hA, lock_indicator);
		@(posedge ref_clk) pll_locked <= 4'h3;
		st();
		st();
		chk("lock_ind", 4'h2, lock_indicator);
		rd(sqa_pkg::OFF_RX_SYNC_LOCK, 8'hA5);
		wr(sqa_pkg::OFF_LOOP_ALIGN, 8'h3C);
		st();
		chk("loopback", 4'hC, serial_loopback_enable);
		chk("tx_en", 4'h3, tx_serial_out_enable);
		chk("align_dis", 4'h3, word_align_disable);
		wr(sqa_pkg::OFF_REALIGN_MC, 8'h52);
		st();
		chk("realign", 4'h2, word_realign_pulse);
		chk("particip", 4'h5, multichan_align_participate);
		st();
		chk("realign", 4'h0, word_realign_pulse);
		wr(sqa_pkg::OFF_REALIGN_MC, 8'h53);
		st();
		chk("realign", 4'h1, word_realign_pulse);
		wr(sqa_pkg::OFF_SYNC_MODE, 8'hD8);
		st();
		chk("groups", 12'h124, {grp_none, grp_twin, grp_quad});
		chk("sync_sel", 8'hD8, multichan_sync_select);
		wr(sqa_pkg::OFF_LINK_SM_SEL, 8'h05);
		for (int i = 0; i < 5; i++) begin
			wr(sqa_pkg::OFF_RESYNC_LINK, rs_d[i]);
			st();
			chk("ptr_rst", rs_p[i], ptr_reset_pulse);
			chk("xaui", (i == 4) ? 4'hF : 4'h5, xaui_sm_use);
		end
		rd(sqa_pkg::OFF_LINK_SM_SEL, 8'h05);
		@(posedge ref_clk) srst <= 1'b1;
		@(posedge ref_clk) srst <= 1'b0;
		st();
		st();
		reset_chk();
		rd(sqa_pkg::OFF_SYNC_MODE, 8'h00);
		rd(sqa_pkg::OFF_LINK_SM_SEL, 8'h00);
		final_report();
	end
endmodule : testbench
`default_nettype wire
